// >>> rtl/bad_pkg.sv
package bad_pkg;
	// Data path widths
	localparam int DATA_W = 16;
	localparam int DIGIT_W = 4;
	localparam int NDIGIT = 4;
	localparam int BYTE_W = 8;
	// Register bank: sixty-four words
	localparam int NREG = 64;
	localparam int RADDR_W = 6;
	// Accumulator reset value
	localparam logic [15:0] ACC_RST = 16'h0000;
	// Largest legal BCD digit
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [3:0] DIGIT_TEN = 4'ha;
	// Operation codes
	typedef enum logic [2:0] {
		BAD_OP_NOP = 3'b000,
		BAD_OP_LDK = 3'b001,
		BAD_OP_LDG = 3'b010,
		BAD_OP_LDR = 3'b011,
		BAD_OP_ADD = 3'b100,
		BAD_OP_SUB = 3'b101,
		BAD_OP_CMP = 3'b110,
		BAD_OP_STR = 3'b111
	} bad_op_t;
	// Flag vector positions
	localparam int FLG_GT = 0;
	localparam int FLG_EQ = 1;
	localparam int FLG_LT = 2;
	localparam int FLG_CY = 3;
	localparam int FLG_ZR = 4;
	localparam int FLG_OV = 5;
	localparam int NFLAG = 6;
endpackage

// >>> rtl/bad_reg_if.sv
`timescale 1ns/1ps
// Register bank port bundle
interface bad_reg_if;
	logic we;
	logic [5:0] waddr;
	logic [15:0] wdata;
	logic [5:0] raddr;
	logic [15:0] rdata;
	modport ctl (output we, waddr, wdata, raddr, input rdata);
	modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

// >>> rtl/bad_regbank.sv
`timescale 1ns/1ps
// Sixty-four word register bank, registered read
module bad_regbank #(
	parameter int NREG = bad_pkg::NREG
) (
	// Clock
	input wire logic i_clk,
	// Port bundle
	bad_reg_if.mem rb
);
	import bad_pkg::*;
	logic [15:0] mem_q [NREG];

	// Write and registered read; no reset, as bank contents persist
	always_ff @(posedge i_clk) begin
		if (rb.we) begin
			mem_q[rb.waddr] <= rb.wdata; // [RULE_06]
		end
		rb.rdata <= mem_q[rb.raddr];
	end
endmodule // bad_regbank

// >>> rtl/bad_accum.sv
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Operands load into one 16-bit accumulator first
// RULE_02: Accumulator holds four packed BCD digits
// RULE_03: Valid values span 0000 to 9999
// RULE_04: Results write back into the accumulator
// RULE_05: Accumulator can go to outputs or registers
// RULE_06: Bank of sixty-four 16-bit registers
// RULE_07: Arithmetic only on valid BCD values
// RULE_08: Accumulator holds until load or computation
// RULE_09: Operand is constant or group reference
// RULE_10: Constant digits stored LSD low, MSD high
// RULE_11: Group: lowest point in accumulator bit 0
// RULE_12: Register word: low byte holds low digits
// RULE_13: Operations set compare, carry, zero, overflow flags
// RULE_14: Accumulator is zero after reset
module bad_accum (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Operation request, one-cycle strobe
	input wire logic i_op_vld,
	input wire bad_pkg::bad_op_t i_op,
	input wire logic [15:0] i_const,
	input wire logic [5:0] i_reg_addr,
	input wire logic i_wide,
	// Discrete point group in
	input wire logic [15:0] i_grp,
	// Outputs
	output logic [15:0] o_acc,
	output logic [15:0] o_grp_out,
	output logic o_grp_we,
	output logic [5:0] o_flags,
	output logic o_busy,
	output logic o_bcd_err
);
	import bad_pkg::*;

	bad_reg_if rb();

	bad_regbank #(.NREG(NREG)) u_bank (
		.i_clk(i_clk),
		.rb(rb)
	);

	typedef enum logic [1:0] {
		BAD_ST_IDLE = 2'b00,
		BAD_ST_READ = 2'b01,
		BAD_ST_EXEC = 2'b10
	} bad_st_t;

	bad_st_t st_q, st_d;
	bad_op_t op_q;
	logic [15:0] acc_q, acc_d;
	logic [5:0] flags_q, flags_d;
	logic [15:0] grp_out_q;
	logic grp_we_q;
	logic bcd_err_q, bcd_err_d;
	logic [15:0] opnd;
	logic [15:0] sum_bcd, dif_bcd;
	logic [4:0] sum_c, dif_b;
	logic acc_ok, opnd_ok;
	logic [3:0] acc_dig_ok, opnd_dig_ok;
	logic [15:0] grp_in;
	logic [15:0] grp_in_m;
	logic [15:0] grp_s1_q, grp_s2_q, grp_s3_q, grp_flt_q, grp_flt_d;
	logic [5:0] addr_q;
	logic busy_q;

	// Points are asynchronous; a bit moves once stages two and three agree
	assign grp_flt_d = (grp_s2_q & grp_s3_q) |
		(grp_flt_q & (grp_s2_q | grp_s3_q));

	// Point synchroniser and filter
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			grp_s1_q <= '0;
			grp_s2_q <= '0;
			grp_s3_q <= '0;
			grp_flt_q <= '0;
		end else begin
			grp_s1_q <= i_grp;
			grp_s2_q <= grp_s1_q;
			grp_s3_q <= grp_s2_q;
			grp_flt_q <= grp_flt_d;
		end
	end

	// Narrow groups take eight points; upper byte reads zero
	assign grp_in_m = i_wide ? grp_flt_q :
		{{(DATA_W - BYTE_W){1'b0}}, grp_flt_q[BYTE_W-1:0]}; // [RULE_11]
	assign grp_in = grp_in_m;

	// Register read port; address held so the caller may move on
	assign rb.raddr = (st_q == BAD_ST_IDLE) ? i_reg_addr :
		addr_q; // [RULE_12]
	assign opnd = rb.rdata;

	// Per-digit adder, subtractor and validity checks
	assign sum_c[0] = 1'b0;
	assign dif_b[0] = 1'b0;
	genvar g;
	generate
		for (g = 0; g < NDIGIT; g++) begin : g_dig
			logic [3:0] a, b;
			logic [4:0] s, d;
			assign a = acc_q[g*DIGIT_W +: DIGIT_W];
			assign b = opnd[g*DIGIT_W +: DIGIT_W];
			assign acc_dig_ok[g] = a <= DIGIT_MAX; // [RULE_03]
			assign opnd_dig_ok[g] = b <= DIGIT_MAX;
			assign s = {1'b0, a} + {1'b0, b} + {4'h0, sum_c[g]};
			assign d = {1'b0, a} - {1'b0, b} - {4'h0, dif_b[g]};
			// Decimal adjust per digit
			assign sum_c[g+1] = s > {1'b0, DIGIT_MAX};
			assign sum_bcd[g*DIGIT_W +: DIGIT_W] = sum_c[g+1] ?
				4'(s - {1'b0, DIGIT_TEN}) : s[3:0]; // [RULE_02]
			assign dif_b[g+1] = d[4];
			assign dif_bcd[g*DIGIT_W +: DIGIT_W] = dif_b[g+1] ?
				4'(d + {1'b0, DIGIT_TEN}) : d[3:0];
		end
	endgenerate
	assign acc_ok = &acc_dig_ok;
	assign opnd_ok = &opnd_dig_ok;

	// Sequencer: register operands need one read cycle
	always_comb begin
		st_d = st_q;
		acc_d = acc_q;
		flags_d = flags_q;
		bcd_err_d = bcd_err_q;
		unique case (st_q)
			BAD_ST_IDLE: begin
				if (i_op_vld) begin
					unique case (i_op)
						BAD_OP_LDK: acc_d = i_const; // [RULE_09] [RULE_10]
						BAD_OP_LDG: acc_d = grp_in; // [RULE_01] [RULE_09]
						BAD_OP_NOP, BAD_OP_STR: acc_d = acc_q; // [RULE_08]
						BAD_OP_LDR, BAD_OP_ADD, BAD_OP_SUB, BAD_OP_CMP:
							st_d = BAD_ST_READ;
					endcase
				end
			end
			BAD_ST_READ: st_d = BAD_ST_EXEC;
			BAD_ST_EXEC: begin
				st_d = BAD_ST_IDLE;
				bcd_err_d = 1'b0;
				if (op_q == BAD_OP_LDR) begin
					acc_d = opnd; // [RULE_01]
				end else if (!(acc_ok && opnd_ok)) begin
					bcd_err_d = 1'b1; // [RULE_07]
				end else begin
					flags_d[FLG_GT] = acc_q > opnd; // [RULE_13]
					flags_d[FLG_EQ] = acc_q == opnd;
					flags_d[FLG_LT] = acc_q < opnd;
					if (op_q == BAD_OP_ADD) begin
						acc_d = sum_bcd; // [RULE_04]
						flags_d[FLG_CY] = sum_c[NDIGIT];
						flags_d[FLG_OV] = sum_c[NDIGIT];
						flags_d[FLG_ZR] = sum_bcd == ACC_RST;
					end else if (op_q == BAD_OP_SUB) begin
						acc_d = dif_bcd; // [RULE_04]
						flags_d[FLG_CY] = dif_b[NDIGIT];
						flags_d[FLG_OV] = 1'b0;
						flags_d[FLG_ZR] = dif_bcd == ACC_RST;
					end
				end
			end
			default: st_d = BAD_ST_IDLE;
		endcase
	end

	// Store to register bank or to discrete outputs
	assign rb.we = i_op_vld && st_q == BAD_ST_IDLE && i_op == BAD_OP_STR &&
		!i_wide; // [RULE_05]
	assign rb.waddr = i_reg_addr;
	assign rb.wdata = acc_q;

	// State registers; accumulator cleared at reset
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q <= BAD_ST_IDLE;
			op_q <= BAD_OP_NOP;
			acc_q <= ACC_RST; // [RULE_14]
			flags_q <= '0;
			bcd_err_q <= 1'b0;
			addr_q <= '0;
			busy_q <= 1'b0;
		end else begin
			st_q <= st_d;
			busy_q <= st_d != BAD_ST_IDLE;
			if (i_op_vld && st_q == BAD_ST_IDLE) begin
				op_q <= i_op;
				addr_q <= i_reg_addr;
			end
			acc_q <= acc_d;
			flags_q <= flags_d;
			bcd_err_q <= bcd_err_d;
		end
	end

	// Group output latch; i_wide selects points instead of bank
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			grp_out_q <= '0;
			grp_we_q <= 1'b0;
		end else begin
			grp_we_q <= i_op_vld && st_q == BAD_ST_IDLE &&
				i_op == BAD_OP_STR && i_wide;
			if (i_op_vld && st_q == BAD_ST_IDLE && i_op == BAD_OP_STR &&
				i_wide) begin
				grp_out_q <= acc_q; // [RULE_05]
			end
		end
	end

	assign o_acc = acc_q;
	assign o_flags = flags_q;
	assign o_grp_out = grp_out_q;
	assign o_grp_we = grp_we_q;
	assign o_busy = busy_q;
	assign o_bcd_err = bcd_err_q;

	chk_acc_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == BAD_ST_IDLE && !i_op_vld) |=> $stable(acc_q)) // [RULE_08]
		else $error("accumulator changed without an operation");
	chk_const_load: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == BAD_ST_IDLE && i_op_vld && i_op == BAD_OP_LDK)
		|=> acc_q == $past(i_const)) // [RULE_10]
		else $error("constant not loaded in order");
	chk_grp_load: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == BAD_ST_IDLE && i_op_vld && i_op == BAD_OP_LDG && !i_wide)
		|=> acc_q[15:8] == 8'h00) // [RULE_11]
		else $error("narrow group loaded upper byte");
	chk_op_done: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == BAD_ST_IDLE && i_op_vld && i_op == BAD_OP_ADD)
		|-> ##1 st_q == BAD_ST_READ ##1 st_q == BAD_ST_EXEC
		##1 st_q == BAD_ST_IDLE) // [RULE_04]
		else $error("add sequence wrong");
	chk_add_bcd: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == BAD_ST_EXEC && op_q == BAD_OP_ADD && acc_ok && opnd_ok)
		|=> acc_q[3:0] <= DIGIT_MAX && acc_q[7:4] <= DIGIT_MAX &&
		acc_q[11:8] <= DIGIT_MAX && acc_q[15:12] <= DIGIT_MAX) // [RULE_02]
		else $error("add result not BCD");
	chk_bad_bcd: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == BAD_ST_EXEC && op_q != BAD_OP_LDR && !(acc_ok && opnd_ok))
		|=> o_bcd_err && $stable(acc_q)) // [RULE_07]
		else $error("arithmetic on non BCD value");
	chk_eq_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == BAD_ST_EXEC && op_q == BAD_OP_CMP && acc_ok && opnd_ok)
		|=> o_flags[FLG_EQ] == ($past(acc_q) == $past(opnd))) // [RULE_13]
		else $error("equal flag wrong");
	chk_grp_out: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		(st_q == BAD_ST_IDLE && i_op_vld && i_op == BAD_OP_STR && i_wide)
		|=> o_grp_we && o_grp_out == $past(acc_q)) // [RULE_05]
		else $error("group output not written");
	cov_add: cover property (@(posedge i_clk) st_q == BAD_ST_EXEC &&
		op_q == BAD_OP_ADD && sum_c[NDIGIT]);
	cov_sub_borrow: cover property (@(posedge i_clk) st_q == BAD_ST_EXEC &&
		op_q == BAD_OP_SUB && dif_b[NDIGIT]);
	cov_store: cover property (@(posedge i_clk) rb.we);
endmodule // bad_accum

// >>> verif/bad_io_model.sv
`timescale 1ns/1ps
// Discrete input points facing the accumulator
module bad_io_model (
	// Clock
	input wire logic i_clk,
	// Bench control
	input wire logic i_drive,
	input wire logic [15:0] i_pat,
	// Points, bit 0 is the lowest point
	output logic [15:0] o_grp
);
	logic [15:0] idle_q = 16'h5a5a;
	// Idle points toggle so a stale value never passes for a good one
	always @(negedge i_clk) begin
		idle_q <= ~idle_q;
	end
	assign o_grp = i_drive ? i_pat : idle_q;
endmodule // bad_io_model

// >>> verif/bad_accum_bench.sv
`timescale 1ns/1ps
module bad_accum_bench;
	import bad_pkg::*;
	logic i_clk = 0, i_sys_rst = 1, i_op_vld = 0, i_wide = 0, drv = 0;
	bad_op_t i_op = BAD_OP_NOP;
	logic [15:0] i_const = 16'h0, pat = 16'h0, i_grp, o_acc, o_grp_out;
	logic [5:0] i_reg_addr = 6'h0, o_flags;
	logic o_grp_we, o_busy, o_bcd_err, we_seen;
	int bad_count = 0, num_checks = 0, cyc = 0;
	bad_accum u_bad_accum (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_op_vld(i_op_vld), .i_op(i_op), .i_const(i_const),
		.i_reg_addr(i_reg_addr), .i_wide(i_wide), .i_grp(i_grp),
		.o_acc(o_acc), .o_grp_out(o_grp_out), .o_grp_we(o_grp_we),
		.o_flags(o_flags), .o_busy(o_busy), .o_bcd_err(o_bcd_err));
	bad_io_model u_bad_io_model (.i_clk(i_clk), .i_drive(drv),
		.i_pat(pat), .o_grp(i_grp));
	// Clock, 25 ns period
	initial begin
		forever #12.5 i_clk = ~i_clk;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Hang guard, far above the hundred or so cycles the tests need
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input logic [15:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One strobe, then wait out busy so the next request is legal
	task automatic op(input bad_op_t o, input logic [15:0] k,
		input logic [5:0] a, input int w);
		int n;
		logic slow;
		slow = o inside {BAD_OP_LDR, BAD_OP_ADD, BAD_OP_SUB, BAD_OP_CMP};
		@(negedge i_clk);
		i_op_vld = 1'b1;
		i_op = o;
		i_const = k;
		i_reg_addr = a;
		i_wide = w[0];
		@(negedge i_clk);
		i_op_vld = 1'b0;
		// Address moves on at once; the block must have kept its own copy
		i_reg_addr = ~a;
		we_seen = o_grp_we;
		chk("busy", {15'h0, slow}, {15'h0, o_busy});
		n = 0;
		while (o_busy !== 1'b0 && n < 20) begin
			@(negedge i_clk);
			n++;
		end
		chk("busy_end", 16'h0, {15'h0, o_busy});
		@(negedge i_clk);
		we_seen |= o_grp_we;
	endtask
	// Points pass a three-stage filter, so let them settle first
	task automatic set_pat(input logic [15:0] p);
		pat = p;
		drv = 1'b1;
		repeat (5) @(negedge i_clk);
	endtask
	task automatic t_load;
		chk("acc", 16'h0000, o_acc);
		op(BAD_OP_LDK, 16'h1234, 6'h0, 0);
		chk("acc", 16'h1234, o_acc);
		op(BAD_OP_NOP, 16'h5555, 6'h0, 0);
		chk("acc", 16'h1234, o_acc);
		$display("test load done");
	endtask
	task automatic t_bank;
		op(BAD_OP_LDK, 16'h9876, 6'h0, 0);
		op(BAD_OP_STR, 16'h0, 6'h3f, 0);
		op(BAD_OP_LDK, 16'h0001, 6'h0, 0);
		op(BAD_OP_STR, 16'h0, 6'h01, 0);
		op(BAD_OP_LDR, 16'h0, 6'h3f, 0);
		chk("acc", 16'h9876, o_acc);
		op(BAD_OP_STR, 16'h0, 6'h0, 1);
		chk("grp_out", 16'h9876, o_grp_out);
		chk("grp_we", 16'h1, {15'h0, we_seen});
		$display("test bank done");
	endtask
	task automatic t_group;
		set_pat(16'ha5c3);
		op(BAD_OP_LDG, 16'h0, 6'h0, 1);
		chk("acc", 16'ha5c3, o_acc);
		op(BAD_OP_LDG, 16'h0, 6'h0, 0);
		chk("acc", 16'h00c3, o_acc);
		set_pat(16'h00ab);
		op(BAD_OP_LDG, 16'h0, 6'h0, 1);
		op(BAD_OP_ADD, 16'h0, 6'h01, 0);
		chk("acc", 16'h00ab, o_acc);
		chk("bcd_err", 16'h1, {15'h0, o_bcd_err});
		drv = 1'b0;
		$display("test group done");
	endtask
	task automatic t_math;
		op(BAD_OP_LDK, 16'h9999, 6'h0, 0);
		op(BAD_OP_ADD, 16'h0, 6'h01, 0);
		chk("acc", 16'h0000, o_acc);
		chk("carry", 16'h1, {15'h0, o_flags[FLG_CY]});
		chk("zero", 16'h1, {15'h0, o_flags[FLG_ZR]});
		chk("ovf", 16'h1, {15'h0, o_flags[FLG_OV]});
		op(BAD_OP_LDK, 16'h0005, 6'h0, 0);
		op(BAD_OP_STR, 16'h0, 6'h02, 0);
		op(BAD_OP_LDK, 16'h0012, 6'h0, 0);
		op(BAD_OP_SUB, 16'h0, 6'h02, 0);
		chk("acc", 16'h0007, o_acc);
		op(BAD_OP_CMP, 16'h0, 6'h02, 0);
		chk("gt", 16'h1, {15'h0, o_flags[FLG_GT]});
		chk("eq", 16'h0, {15'h0, o_flags[FLG_EQ]});
		chk("lt", 16'h0, {15'h0, o_flags[FLG_LT]});
		chk("acc", 16'h0007, o_acc);
		op(BAD_OP_LDK, 16'h0005, 6'h0, 0);
		op(BAD_OP_CMP, 16'h0, 6'h02, 0);
		chk("eq", 16'h1, {15'h0, o_flags[FLG_EQ]});
		chk("gt", 16'h0, {15'h0, o_flags[FLG_GT]});
		$display("test math done");
	endtask
	initial begin
		repeat (12) @(posedge i_clk);
		@(negedge i_clk);
		i_sys_rst = 0;
		t_load();
		t_bank();
		t_group();
		t_math();
		give_verdict();
	end
endmodule // bad_accum_bench
